/* src/system_clock_control.v */
// Behaviour
// [R1] system clock muxed: osc, osc/256, multiplied
// [R2] machine cycle tick is system tick divided four
// [R3] system tick drives timers and peripherals
// [R4] select 00 uses multiplier, factor picks 2x/4x
// [R5] select codes: 00 mult, 01 reserved, 10, 11
// [R6] new select applies at next machine tick
// [R7] software passes every change through divide-by-4
// [R8] illegal select transitions rejected, bits unchanged
// [R9] engage only from divide-by-4, ring inactive, ordered
// [R10] software: clear enable, factor, enable, poll, 00
// [R11] ready flag after 65536 oscillator ticks
// [R12] multiplier engaged machine cycle after 00 write
// [R13] leaving multiplier needs only a select write
// [R14] other accesses between sequence steps are harmless
// [R15] enabled fail detect holds cpu reset when slow
// [R16] fail-detect enable written only by timed access
// [R17] fail flag set on failure, cleared power-fail/software
// [R18] no fail detection while in stop mode
// [R19] timed access: aa then 55 just before write
// [R20] clearing enable stops multiplier, clears ready flag
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`include "system_clock_control_regs.vh"
module system_clock_control #(
  parameter LOCK_TICKS = `LOCK_OSC_TICKS
) (
  input  wire        CLOCK_I,
  input  wire        RST_I,
  input  wire        PSEL_I,
  input  wire        PENABLE_I,
  input  wire        PWRITE_I,
  input  wire [7:0]  PADDR_I,
  input  wire [31:0] PWDATA_I,
  input  wire        OSC_TICK_I,
  input  wire        RING_OSC_ACTIVE_I,
  input  wire        STOP_MODE_I,
  input  wire        OSC_LOW_I,
  input  wire        PWR_FAIL_RST_I,
  output reg  [31:0] PRDATA_O,
  output reg         PREADY_O,
  output reg         PSLVERR_O,
  output reg         SYS_TICK_O,
  output reg         MACH_TICK_O,
  output reg         CPU_RESET_O
);

  // ****************************************************************
  // state
  // ****************************************************************
  localparam [1:0] SEQ_IDLE    = 2'h0;
  localparam [1:0] SEQ_CLEARED = 2'h1;
  localparam [1:0] SEQ_FACTOR  = 2'h2;
  localparam [1:0] SEQ_ARMED   = 2'h3;
  localparam [1:0] TA_IDLE     = 2'h0;
  localparam [1:0] TA_HALF     = 2'h1;
  localparam [1:0] TA_OPEN     = 2'h2;

  reg  [1:0]  active_sel;
  reg  [1:0]  pend_sel;
  reg         pend_valid;
  reg         mult_factor_sel;
  reg         mult_enable;
  reg         mult_ready_flag;
  reg  [1:0]  seq;
  reg  [31:0] lock_cnt;
  reg         osc_fail_enable;
  reg         osc_fail_flag;
  reg  [1:0]  ta_state;
  reg  [7:0]  div_cnt;
  reg  [15:0] per_cnt;
  reg  [15:0] period;
  reg  [15:0] frac_cnt;
  reg  [1:0]  phase;
  reg  [1:0]  mcyc_cnt;

  reg  [7:0]  next_div;
  reg  [15:0] next_frac;
  reg  [1:0]  next_phase;
  reg  [1:0]  next_mcyc;
  reg         next_sys;
  reg         next_mach;
  reg         slow_tick;
  reg         mult_tick;
  reg  [15:0] step;
  reg  [31:0] next_rdata;

  // ****************************************************************
  // decode
  // ****************************************************************
  function sel_allowed;
    input [1:0] cur;
    input [1:0] req;
    input       armed;
    begin
      if (req == cur) begin
        sel_allowed = 1'b1;
      end else if (req == `SEL_RSVD) begin
        sel_allowed = 1'b0;
      end else if (cur == `SEL_DIV4) begin
        sel_allowed = (req == `SEL_MULT) ? armed : 1'b1;
      end else begin
        sel_allowed = (req == `SEL_DIV4);
      end
    end
  endfunction

  wire        setup    = PSEL_I & ~PENABLE_I;
  wire        access   = PSEL_I & PENABLE_I & PREADY_O;
  wire        wr       = access & PWRITE_I;
  wire        wr_mgmt  = wr & (PADDR_I == `MGMT_OFFSET);
  wire        wr_pcr   = wr & (PADDR_I == `PCR_OFFSET);
  wire        wr_tac   = wr & (PADDR_I == `TAC_OFFSET);
  wire        mapped   = (PADDR_I == `MGMT_OFFSET) | (PADDR_I == `EXF_OFFSET) |
                         (PADDR_I == `PCR_OFFSET) | (PADDR_I == `TAC_OFFSET);
  wire [1:0]  cur_sel  = pend_valid ? pend_sel : active_sel;
  wire [1:0]  req_sel  = {PWDATA_I[`MGMT_SEL_HI_BIT], PWDATA_I[`MGMT_SEL_LO_BIT]};
  wire        seq_ok   = (cur_sel == `SEL_DIV4) & ~RING_OSC_ACTIVE_I;
  wire        armed    = (seq == SEQ_ARMED) & mult_enable & mult_ready_flag & seq_ok;
  wire        mult_use = (active_sel == `SEL_MULT) | (cur_sel == `SEL_MULT);
  wire        w_en     = PWDATA_I[`MGMT_MEN_BIT];
  wire        w_fact   = PWDATA_I[`MGMT_FACT_BIT];
  wire        fail_now = osc_fail_enable & OSC_LOW_I & ~STOP_MODE_I; // [R15] [R18]

  // ****************************************************************
  // apb slave
  // ****************************************************************
  always @* begin
    next_rdata = 32'h0;
    case (PADDR_I)
      `MGMT_OFFSET: begin
        next_rdata[`MGMT_SEL_HI_BIT] = cur_sel[1];
        next_rdata[`MGMT_SEL_LO_BIT] = cur_sel[0];
        next_rdata[`MGMT_MEN_BIT]    = mult_enable;
        next_rdata[`MGMT_FACT_BIT]   = mult_factor_sel;
      end
      `EXF_OFFSET: begin
        next_rdata[`EXF_RDY_BIT]  = mult_ready_flag;
        next_rdata[`EXF_RING_BIT] = RING_OSC_ACTIVE_I;
      end
      `PCR_OFFSET: begin
        next_rdata[`PCR_OFF_BIT] = osc_fail_flag;
        next_rdata[`PCR_OFE_BIT] = osc_fail_enable;
      end
      default: begin
        next_rdata = 32'h0;
      end
    endcase
  end

  // no wait states: data and ready are registered in the setup cycle
  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      PRDATA_O  <= 32'h0;
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
    end else begin
      PREADY_O  <= setup;
      PSLVERR_O <= setup & ~mapped;
      if (setup & ~PWRITE_I) begin
        PRDATA_O <= next_rdata;
      end
    end
  end

  // ****************************************************************
  // clock select
  // ****************************************************************
  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      active_sel <= `SEL_RESET;
      pend_sel   <= `SEL_RESET;
      pend_valid <= 1'b0;
    end else if (wr_mgmt && (req_sel != cur_sel) && sel_allowed(cur_sel, req_sel, armed)) begin
      // a rejected request leaves both copies untouched
      pend_sel   <= req_sel; // [R8] [R9] [R13]
      pend_valid <= 1'b1;
    end else if (MACH_TICK_O && pend_valid) begin
      active_sel <= pend_sel; // [R6] [R12]
      pend_valid <= 1'b0;
    end
  end

  // ****************************************************************
  // multiplier engagement sequence
  // ****************************************************************
  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      mult_factor_sel <= 1'b0;
      mult_enable     <= 1'b0;
      seq             <= SEQ_IDLE;
    end else if (wr_mgmt && !mult_use) begin
      // enable and factor are frozen while the multiplier clocks the core
      if (!w_en) begin
        mult_enable <= 1'b0; // [R20]
        if (seq == SEQ_CLEARED || seq == SEQ_FACTOR) begin
          mult_factor_sel <= w_fact; // [R4]
          seq             <= seq_ok ? SEQ_FACTOR : SEQ_IDLE; // [R9]
        end else begin
          seq <= seq_ok ? SEQ_CLEARED : SEQ_IDLE; // [R9]
        end
      end else begin
        mult_enable <= 1'b1;
        if (seq == SEQ_FACTOR && seq_ok) begin
          seq <= SEQ_ARMED; // [R14]
        end else if (!mult_enable) begin
          seq <= SEQ_IDLE; // [R9]
        end
      end
    end
  end

  // lock counts oscillator ticks, not core clocks
  always @(posedge CLOCK_I) begin
    if (RST_I || !mult_enable) begin
      lock_cnt        <= 32'h0;
      mult_ready_flag <= 1'b0; // [R20]
    end else if (OSC_TICK_I && !mult_ready_flag) begin
      lock_cnt <= lock_cnt + 32'h1;
      if (lock_cnt == LOCK_TICKS - 1) begin
        mult_ready_flag <= 1'b1; // [R11]
      end
    end
  end

  // ****************************************************************
  // tick generation
  // ****************************************************************
  always @* begin
    next_div  = div_cnt;
    slow_tick = 1'b0;
    if (OSC_TICK_I) begin
      next_div  = div_cnt + 8'h1;
      slow_tick = (div_cnt == `SLOW_DIV_LAST); // [R1]
    end
    step       = mult_factor_sel ? {2'h0, period[15:2]} : {1'h0, period[15:1]};
    mult_tick  = 1'b0;
    next_frac  = frac_cnt + 16'h1;
    next_phase = phase;
    if (OSC_TICK_I) begin
      mult_tick  = 1'b1;
      next_frac  = 16'h0;
      next_phase = 2'h0;
    end else if (mult_enable && (step != 16'h0) && (next_frac >= step) &&
                 (phase != (mult_factor_sel ? 2'h3 : 2'h1))) begin
      // extra ticks between oscillator edges; limited so none lands on an edge
      mult_tick  = 1'b1; // [R4]
      next_frac  = 16'h0;
      next_phase = phase + 2'h1;
    end
    case (active_sel) // [R1] [R5]
      `SEL_MULT: next_sys = mult_tick;
      `SEL_SLOW: next_sys = slow_tick;
      `SEL_DIV4: next_sys = OSC_TICK_I;
      default:   next_sys = OSC_TICK_I;
    endcase
    next_mcyc = next_sys ? mcyc_cnt + 2'h1 : mcyc_cnt;
    next_mach = next_sys && (mcyc_cnt == `MCYC_LAST); // [R2]
  end

  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      div_cnt     <= 8'h0;
      per_cnt     <= 16'h0;
      period      <= 16'h0;
      frac_cnt    <= 16'h0;
      phase       <= 2'h0;
      mcyc_cnt    <= 2'h0;
      SYS_TICK_O  <= 1'b0;
      MACH_TICK_O <= 1'b0;
    end else begin
      div_cnt  <= next_div;
      frac_cnt <= next_frac;
      phase    <= next_phase;
      mcyc_cnt <= next_mcyc;
      if (OSC_TICK_I) begin
        period  <= per_cnt + 16'h1;
        per_cnt <= 16'h0;
      end else if (per_cnt != `PERIOD_MAX) begin
        per_cnt <= per_cnt + 16'h1;
      end
      SYS_TICK_O  <= next_sys; // [R3]
      MACH_TICK_O <= next_mach; // [R2]
    end
  end

  // ****************************************************************
  // timed access and oscillator-fail detect
  // ****************************************************************
  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      ta_state <= TA_IDLE;
    end else if (wr) begin
      // any other write in between closes the window
      if (wr_tac && PWDATA_I[7:0] == `TA_KEY1) begin
        ta_state <= TA_HALF; // [R19]
      end else if (wr_tac && PWDATA_I[7:0] == `TA_KEY2 && ta_state == TA_HALF) begin
        ta_state <= TA_OPEN; // [R19]
      end else begin
        ta_state <= TA_IDLE;
      end
    end
  end

  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      osc_fail_enable <= 1'b0;
      osc_fail_flag   <= 1'b0;
      CPU_RESET_O     <= 1'b0;
    end else begin
      if (wr_pcr && ta_state == TA_OPEN) begin
        osc_fail_enable <= PWDATA_I[`PCR_OFE_BIT]; // [R16]
      end
      // a failure in the clearing cycle wins over the clear
      if (fail_now) begin
        osc_fail_flag <= 1'b1; // [R17]
      end else if (PWR_FAIL_RST_I) begin
        osc_fail_flag <= 1'b0; // [R17]
      end else if (wr_pcr && !PWDATA_I[`PCR_OFF_BIT]) begin
        osc_fail_flag <= 1'b0; // [R17]
      end
      CPU_RESET_O <= fail_now; // [R15]
    end
  end

endmodule // system_clock_control

/* src/system_clock_control_regs.vh */
`ifndef SYSTEM_CLOCK_CONTROL_REGS_VH
`define SYSTEM_CLOCK_CONTROL_REGS_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define MGMT_OFFSET     8'h00
`define EXF_OFFSET      8'h04
`define PCR_OFFSET      8'h08
`define TAC_OFFSET      8'h0c

// ****************************************************************
// field positions
// ****************************************************************
`define MGMT_SEL_HI_BIT 7
`define MGMT_SEL_LO_BIT 6
`define MGMT_MEN_BIT    4
`define MGMT_FACT_BIT   3
`define EXF_RDY_BIT     4
`define EXF_RING_BIT    2
`define PCR_OFF_BIT     5
`define PCR_OFE_BIT     4

// ****************************************************************
// clock select codes and reset values
// ****************************************************************
`define SEL_MULT        2'h0
`define SEL_RSVD        2'h1
`define SEL_DIV4        2'h2
`define SEL_SLOW        2'h3
`define SEL_RESET       2'h2

// ****************************************************************
// timed access keys
// ****************************************************************
`define TA_KEY1         8'haa
`define TA_KEY2         8'h55

// ****************************************************************
// timing counts
// ****************************************************************
`define LOCK_OSC_TICKS  65536
`define SLOW_DIV_LAST   8'hff
`define MCYC_LAST       2'h3
`define PERIOD_MAX      16'hffff

`endif

/* testbench/clock_control_sva.sv */
`timescale 1ns/1ps
`include "system_clock_control_regs.vh"
module clock_control_sva (
  input wire        CLOCK_I,
  input wire        RST_I,
  input wire        PSEL_I,
  input wire        PENABLE_I,
  input wire        PWRITE_I,
  input wire [7:0]  PADDR_I,
  input wire        OSC_LOW_I,
  input wire        STOP_MODE_I,
  input wire [31:0] PRDATA_O,
  input wire        PREADY_O,
  input wire        PSLVERR_O,
  input wire        SYS_TICK_O,
  input wire        MACH_TICK_O,
  input wire        CPU_RESET_O
);
  // ****
  // properties
  // ****
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  wire      setup = PSEL_I && !PENABLE_I;
  wire      bad   = (PADDR_I > `TAC_OFFSET) || (PADDR_I[1:0] != 2'h0);
  reg [2:0] nsys;
  // a coinciding tick restarts the count, so both phasings give four
  always @(posedge CLOCK_I) begin
    if (RST_I || MACH_TICK_O) nsys <= 3'h0;
    else if (SYS_TICK_O) nsys <= nsys + 3'h1;
  end
  property p_ready; setup |=> PREADY_O; endproperty
  property p_ready_cause; PREADY_O |-> $past(setup); endproperty
  property p_err; setup |=> PSLVERR_O == $past(bad); endproperty
  property p_rdata; !(setup && !PWRITE_I) |=> $stable(PRDATA_O); endproperty
  property p_mach4; MACH_TICK_O |-> (nsys + SYS_TICK_O) == 3'h4; endproperty
  property p_mach_pulse; MACH_TICK_O |=> !MACH_TICK_O; endproperty
  property p_fail_cause; $rose(CPU_RESET_O) |-> $past(OSC_LOW_I) && !$past(STOP_MODE_I);
  endproperty
  property p_fail_hold; CPU_RESET_O && OSC_LOW_I && !STOP_MODE_I |=> CPU_RESET_O; endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  a_ready_cause: assert property (p_ready_cause) else $error("stray ready");
  a_err: assert property (p_err) else $error("wrong slave error");
  a_rdata: assert property (p_rdata) else $error("read data moved");
  a_mach4: assert property (p_mach4) else $error("machine tick not every fourth");
  a_mach_pulse: assert property (p_mach_pulse) else $error("machine tick too long");
  a_fail_cause: assert property (p_fail_cause) else $error("reset without fail");
  a_fail_hold: assert property (p_fail_hold) else $error("reset dropped");
  c_fail: cover property (CPU_RESET_O);
  c_err: cover property (setup ##1 PSLVERR_O);
  c_mach: cover property (MACH_TICK_O);
endmodule // clock_control_sva
bind system_clock_control clock_control_sva u_sva (.CLOCK_I(CLOCK_I), .RST_I(RST_I),
  .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
  .OSC_LOW_I(OSC_LOW_I), .STOP_MODE_I(STOP_MODE_I), .PRDATA_O(PRDATA_O),
  .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .SYS_TICK_O(SYS_TICK_O),
  .MACH_TICK_O(MACH_TICK_O), .CPU_RESET_O(CPU_RESET_O));

/* testbench/osc_source.sv */
`timescale 1ns/1ps
module osc_source (
  input  wire       clk_i,
  input  wire [3:0] period_i,
  input  wire       halt_i,
  output reg        tick_o,
  output wire       low_o
);
  // ****
  // oscillator
  // ****
  reg [3:0] cnt;
  // halted oscillator gives no ticks and reads as below the fail threshold
  assign low_o = halt_i;
  always @(posedge clk_i) begin
    tick_o <= 1'b0;
    if (halt_i) cnt <= 4'h0;
    else if (cnt == period_i) begin
      cnt    <= 4'h1;
      tick_o <= 1'b1;
    end else cnt <= cnt + 4'h1;
  end
endmodule // osc_source

/* testbench/testbench.sv */
`timescale 1ns/1ps
`include "system_clock_control_regs.vh"
module testbench;
  // ****
  // bench
  // ****
  reg         clk, rst, psel, penable, pwrite, ring, stop, halt, pwr_fail;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata, rd;
  reg  [3:0]  period;
  reg  [64:0] e;
  reg  [64:0] exp_q[$];
  wire [31:0] prdata;
  wire        pready, pslverr, sys_tick, mach_tick, cpu_reset, osc_tick, osc_low;
  int         n_fail = 0, comparisons = 0, i, k, n;
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  osc_source u_osc (.clk_i(clk), .period_i(period), .halt_i(halt), .tick_o(osc_tick),
    .low_o(osc_low));
  system_clock_control #(.LOCK_TICKS(8)) dut (.CLOCK_I(clk), .RST_I(rst), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .OSC_TICK_I(osc_tick), .RING_OSC_ACTIVE_I(ring), .STOP_MODE_I(stop),
    .OSC_LOW_I(osc_low), .PWR_FAIL_RST_I(pwr_fail), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .SYS_TICK_O(sys_tick), .MACH_TICK_O(mach_tick),
    .CPU_RESET_O(cpu_reset));
  task chk(input [31:0] got, input [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  always @(posedge clk) if (psel && penable && pready) begin
    e = exp_q.pop_front();
    chk({31'h0, pslverr}, {31'h0, e[64]});
    chk(prdata & e[63:32], e[31:0]);
  end
  task apb(input w, input [7:0] a, input [31:0] d, input [31:0] m, x, input err);
    exp_q.push_back({err, m, x});
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    // the slave sets the pace; only the watchdog ends a stalled wait
    do @(posedge clk); while (!pready);
    rd = prdata;
    psel <= 0; penable <= 0;
  endtask
  task wr(input [7:0] a, input [31:0] d); apb(1, a, d, 0, 0, 0); endtask
  task rdc(input [7:0] a, input [31:0] m, x); apb(0, a, 0, m, x, 0); endtask
  // counts system ticks across m oscillator periods
  task meas(input int m);
    n = 0;
    @(posedge clk iff osc_tick);
    for (k = 0; k < m; ) begin
      @(posedge clk);
      if (sys_tick) n++;
      if (osc_tick) k++;
    end
  endtask
  task settle; @(posedge clk iff mach_tick); @(posedge clk); endtask
  task conclude;
    if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #400000;
    n_fail++;
    conclude;
  end
  initial begin
    rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    ring = 0; stop = 0; halt = 1; pwr_fail = 0;
    i = $urandom(6418);
    period = 4'h8 + 4'($urandom_range(3, 0));
    repeat (8) @(posedge clk);
    rst <= 0; halt <= 0;
    rdc(`MGMT_OFFSET, 32'hff, 32'h80);
    rdc(`PCR_OFFSET, 32'hff, 0);
    apb(0, 8'h10, 0, 0, 0, 1);
    meas(4);
    chk(n, 4);
    wr(`MGMT_OFFSET, 32'h40);
    rdc(`MGMT_OFFSET, 32'hc0, 32'h80);
    wr(`MGMT_OFFSET, 32'hc0);
    settle;
    rdc(`MGMT_OFFSET, 32'hc0, 32'hc0);
    meas(512);
    chk(n, 2);
    wr(`MGMT_OFFSET, 32'h00);
    rdc(`MGMT_OFFSET, 32'hc0, 32'hc0);
    wr(`MGMT_OFFSET, 32'h80);
    settle;
    ring <= 1;
    wr(`MGMT_OFFSET, 32'h80);
    wr(`MGMT_OFFSET, 32'h88);
    wr(`MGMT_OFFSET, 32'h98);
    rdc(`EXF_OFFSET, 32'h04, 32'h04);
    repeat (200) @(posedge clk);
    wr(`MGMT_OFFSET, 32'h18);
    rdc(`MGMT_OFFSET, 32'hc0, 32'h80);
    ring <= 0;
    wr(`MGMT_OFFSET, 32'h98);
    repeat (200) @(posedge clk);
    wr(`MGMT_OFFSET, 32'h18);
    rdc(`MGMT_OFFSET, 32'hc0, 32'h80);
    for (i = 0; i < 2; i++) begin
      wr(`MGMT_OFFSET, 32'h80);
      wr(`MGMT_OFFSET, 32'h80 | i << 3);
      wr(`MGMT_OFFSET, 32'h90 | i << 3);
      rdc(`EXF_OFFSET, 32'h10, 0);
      rd = 0;
      for (k = 0; k < 200 && !rd[4]; k++) begin
        apb(0, 8'h20, 0, 0, 0, 1);
        apb(0, `EXF_OFFSET, 0, 0, 0, 0);
      end
      chk(rd[4], 1);
      wr(`MGMT_OFFSET, 32'h10 | i << 3);
      settle;
      rdc(`MGMT_OFFSET, 32'hc0, 0);
      meas(4);
      chk(n, 8 << i);
      wr(`MGMT_OFFSET, 32'h90 | i << 3);
      settle;
      meas(4);
      chk(n, 4);
      wr(`MGMT_OFFSET, 32'h80);
      rdc(`EXF_OFFSET, 32'h10, 0);
    end
    wr(`PCR_OFFSET, 32'h10); halt <= 1;
    repeat (20) @(posedge clk);
    chk(cpu_reset, 0);
    halt <= 0;
    wr(`TAC_OFFSET, 32'haa); wr(`TAC_OFFSET, 32'h55); wr(`PCR_OFFSET, 32'h10);
    rdc(`PCR_OFFSET, 32'h10, 32'h10);
    for (i = 0; i < 2; i++) begin
      stop <= 1; halt <= 1;
      repeat (20) @(posedge clk);
      chk(cpu_reset, 0);
      stop <= 0;
      repeat (3) @(posedge clk);
      chk(cpu_reset, 1);
      rdc(`PCR_OFFSET, 32'h20, 32'h20);
      halt <= 0;
      repeat (3) @(posedge clk);
      if (i == 0) wr(`PCR_OFFSET, 32'h10);
      else begin
        pwr_fail <= 1;
        @(posedge clk);
        pwr_fail <= 0;
      end
      rdc(`PCR_OFFSET, 32'h20, 0);
    end
    conclude;
  end
endmodule // testbench
